// ==== core/trh_reader.sv ====
// tape reader drive control, character handshake and apb status port
// Summary of operation
// - high is logic 1; active-low lines are treated as inverted signals
// - character-ready drops as soon as a new drive command rises
// - read mode accepts a single-step pulse or a continuous level
// - read mode moves tape at about 200 characters per second
// - read mode with spooler: reversal locks out drive up to 320 ms
// - one direction at a time; both keeps the last direction
// - wind mode moves tape at about 400 characters per second
// - unsynchronised wind-mode drive may be locked out by the device
// - wind-mode stop locks out drive for 30 to 55 ms
// - wind-mode reversal holds off new drive 320 ms after previous drive
// - fast-wind inputs accept the same active-low drive signalling
// - direction inputs command motion when low, stop when high
// - halt request stops motion and forces both ready outputs inactive
// - tracks and ready active-high when polarity select low, else active-low
// - each track output asserted when its hole is present
// - unit ready only in run position with no disabling condition
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module trh_reader #(
  parameter int READ_CHAR_CYC = trh_pkg::READ_CHAR_CYC,
  parameter int WIND_CHAR_CYC = trh_pkg::WIND_CHAR_CYC,
  parameter int STOP_WIN_CYC = trh_pkg::STOP_WIN_CYC,
  parameter int REV_LOCK_CYC = trh_pkg::REV_LOCK_CYC,
  parameter int WIND_LOCK_CYC = trh_pkg::WIND_LOCK_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host drive commands, active low, and the output polarity select
  input wire logic run_left_cmd_n,
  input wire logic run_right_cmd_n,
  input wire logic fast_left_cmd_n,
  input wire logic fast_right_cmd_n,
  input wire logic wind_enable_n,
  input wire logic halt_request_n,
  input wire logic polarity_sel,
  // read head
  input wire logic [7:0] tape_holes,
  input wire logic tape_out,
  // host outputs
  output logic [7:0] track_out,
  output logic char_ready_out,
  output logic unit_ready_n
);

  trh_pkg::trh_state_t state_r;
  trh_pkg::trh_state_t state_nxt;
  trh_pkg::trh_cmd_t cmd;
  trh_pkg::trh_char_t chr_r;
  logic [trh_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] win_r;
  logic [31:0] win_nxt;
  logic [31:0] char_count_r;
  logic dir_right_r;
  logic want_right;
  logic any_req;
  logic any_req_d_r;
  logic req_rise;
  logic unit_ready;
  logic reversed;
  logic rev_busy;
  logic wind_busy;
  logic blocked;
  logic start;
  logic arrive;
  logic stop_evt;
  logic resume;
  logic got_char;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic [31:0] status;

  // command decode; high or open means stop on every drive line
  always_comb
  begin
    cmd.wind = ~wind_enable_n;
    cmd.left = ~run_left_cmd_n | ctrl_r[trh_pkg::CTRL_MAN_LEFT];
    cmd.right = ~run_right_cmd_n | ctrl_r[trh_pkg::CTRL_MAN_RIGHT];
    if (cmd.wind)
    begin
      cmd.left = cmd.left | ~fast_left_cmd_n;
      cmd.right = cmd.right | ~fast_right_cmd_n;
    end
  end

  // both directions at once keep the last one rather than forcing a reversal
  always_comb
  begin
    if (cmd.left && cmd.right)
      want_right = dir_right_r;
    else
      want_right = cmd.right;
  end

  assign any_req = cmd.left | cmd.right;
  assign req_rise = any_req & ~any_req_d_r;

  // out-of-tape is the one disabling condition modelled besides halt
  assign unit_ready = ctrl_r[trh_pkg::CTRL_LOAD_RUN] & halt_request_n & ~tape_out;

  // reversal lockout applies in read mode only with the spooler enabled
  assign reversed = (want_right != dir_right_r);
  always_comb
  begin
    blocked = 1'b0;
    if (cmd.wind && wind_busy)
      blocked = 1'b1;
    if (reversed && rev_busy && (cmd.wind || ctrl_r[trh_pkg::CTRL_SPOOL_EN]))
      blocked = 1'b1;
  end

  // a level or a pulse both start a step; only the decision after arrival differs
  assign start = (state_r == trh_pkg::TRH_IDLE) & any_req & unit_ready & ~blocked;
  assign arrive = (state_r == trh_pkg::TRH_MOVE) & (cnt_r == 32'h0000_0001);

  // next state and character timing
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    case (state_r)
      trh_pkg::TRH_IDLE:
      begin
        if (start)
        begin
          state_nxt = trh_pkg::TRH_MOVE;
          if (cmd.wind)
            cnt_nxt = WIND_CHAR_CYC;
          else
            cnt_nxt = READ_CHAR_CYC;
        end
      end
      trh_pkg::TRH_MOVE:
      begin
        if (cmd.wind && !any_req)
          state_nxt = trh_pkg::TRH_IDLE;
        else if (arrive)
        begin
          state_nxt = trh_pkg::TRH_SHOW;
          win_nxt = STOP_WIN_CYC;
        end
        else
          cnt_nxt = cnt_r - 32'h0000_0001;
      end
      trh_pkg::TRH_SHOW:
      begin
        // a pulse already released, or a withdrawn level, stops on this character
        if (!any_req || (reversed && !(cmd.left && cmd.right)))
          state_nxt = trh_pkg::TRH_IDLE;
        else if (req_rise || win_r == 32'h0000_0001)
        begin
          state_nxt = trh_pkg::TRH_MOVE;
          if (cmd.wind)
            cnt_nxt = WIND_CHAR_CYC - STOP_WIN_CYC;
          else
            cnt_nxt = READ_CHAR_CYC - STOP_WIN_CYC;
        end
        else
          win_nxt = win_r - 32'h0000_0001;
      end
      default:
        state_nxt = trh_pkg::TRH_IDLE;
    endcase
    if (!unit_ready)
      state_nxt = trh_pkg::TRH_IDLE;
  end

  assign stop_evt = (state_r != trh_pkg::TRH_IDLE) & (state_nxt == trh_pkg::TRH_IDLE);
  // tape leaving a shown character under a held level drops ready so the next one is seen
  assign resume = (state_r == trh_pkg::TRH_SHOW) & (state_nxt == trh_pkg::TRH_MOVE);
  assign got_char = arrive & ~(cmd.wind & ~any_req) & unit_ready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= trh_pkg::TRH_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 32'h0000_0000;
      win_r <= 32'h0000_0000;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      any_req_d_r <= 1'b0;
    else
      any_req_d_r <= any_req;
  end

  // direction is committed only when a step actually starts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_right_r <= 1'b1;
    else if (start)
      dir_right_r <= want_right;
  end

  // both lockouts run from the end of the previous drive
  trh_timer #(
    .W(32)
  ) u_rev_lock (
    .pclk(pclk),
    .presetn(presetn),
    .start(stop_evt),
    .length(32'(REV_LOCK_CYC)),
    .busy(rev_busy)
  );

  trh_timer #(
    .W(32)
  ) u_wind_lock (
    .pclk(pclk),
    .presetn(presetn),
    .start(stop_evt & cmd.wind),
    .length(32'(WIND_LOCK_CYC)),
    .busy(wind_busy)
  );

  // character latch; tracks change only on arrival, while ready is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chr_r <= '0;
    else if (!unit_ready)
      chr_r.ready <= 1'b0;
    else if (req_rise || start || resume)
      chr_r.ready <= 1'b0;
    else if (arrive && !(cmd.wind && !any_req))
    begin
      chr_r.tracks <= tape_holes;
      chr_r.ready <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      char_count_r <= 32'h0000_0000;
    else if (apb_wr && paddr == trh_pkg::COUNT_OFS)
      char_count_r <= {31'h0000_0000, got_char};
    else if (got_char)
      char_count_r <= char_count_r + 32'h0000_0001;
  end

  // pins; output sense follows the polarity select, ready line is true low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      track_out <= 8'h00;
      char_ready_out <= 1'b0;
      unit_ready_n <= 1'b1;
    end
    else
    begin
      track_out <= chr_r.tracks ^ {8{polarity_sel}};
      // gated so ready falls on the same edge as unit ready, not one cycle later
      char_ready_out <= (chr_r.ready & unit_ready) ^ polarity_sel;
      unit_ready_n <= ~unit_ready;
    end
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign addr_ok = (paddr == trh_pkg::CTRL_OFS) | (paddr == trh_pkg::STATUS_OFS)
    | (paddr == trh_pkg::DATA_OFS) | (paddr == trh_pkg::COUNT_OFS);
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= trh_pkg::CTRL_RESET;
    else if (apb_wr && paddr == trh_pkg::CTRL_OFS)
      ctrl_r <= pwdata[trh_pkg::CTRL_W-1:0];
  end

  always_comb
  begin
    status = 32'h0000_0000;
    status[trh_pkg::ST_UNIT_READY] = unit_ready;
    status[trh_pkg::ST_CHAR_READY] = chr_r.ready;
    status[trh_pkg::ST_MOVING] = (state_r != trh_pkg::TRH_IDLE);
    status[trh_pkg::ST_DIR_RIGHT] = dir_right_r;
    status[trh_pkg::ST_REV_LOCK] = rev_busy;
    status[trh_pkg::ST_WIND_LOCK] = wind_busy;
    status[trh_pkg::ST_WIND_MODE] = cmd.wind;
    status[trh_pkg::ST_STATE_LSB+1:trh_pkg::ST_STATE_LSB] = state_r;
  end

  // read data is combinational on the access phase so it is valid at the sampling edge
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (apb_rd)
    begin
      case (paddr)
        trh_pkg::CTRL_OFS:
          prdata = {28'h000_0000, ctrl_r};
        trh_pkg::STATUS_OFS:
          prdata = status;
        trh_pkg::DATA_OFS:
          prdata = {24'h00_0000, chr_r.tracks};
        trh_pkg::COUNT_OFS:
          prdata = char_count_r;
        default:
          prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== core/trh_pkg.sv ====
// shared constants and carrier types of the tape reader drive handshake
package trh_pkg;

  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int READ_CPS = 200;
  localparam int WIND_CPS = 400;
  localparam int READ_CHAR_CYC = CLK_HZ / READ_CPS;
  localparam int WIND_CHAR_CYC = CLK_HZ / WIND_CPS;
  localparam int STOP_WIN_US = 500;
  localparam int STOP_WIN_CYC = STOP_WIN_US * CLK_PER_US;
  localparam int REV_LOCK_MS = 320;
  localparam int REV_LOCK_CYC = REV_LOCK_MS * 1000 * CLK_PER_US;
  localparam int WIND_LOCK_MIN_MS = 30;
  localparam int WIND_LOCK_MAX_MS = 55;
  localparam int WIND_LOCK_CYC = WIND_LOCK_MIN_MS * 1000 * CLK_PER_US;

  // register map, byte addresses
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] DATA_OFS = 12'h008;
  localparam logic [11:0] COUNT_OFS = 12'h00C;

  // control fields
  localparam int CTRL_LOAD_RUN = 0;
  localparam int CTRL_SPOOL_EN = 1;
  localparam int CTRL_MAN_LEFT = 2;
  localparam int CTRL_MAN_RIGHT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h3;

  // status fields
  localparam int ST_UNIT_READY = 0;
  localparam int ST_CHAR_READY = 1;
  localparam int ST_MOVING = 2;
  localparam int ST_DIR_RIGHT = 3;
  localparam int ST_REV_LOCK = 4;
  localparam int ST_WIND_LOCK = 5;
  localparam int ST_WIND_MODE = 6;
  localparam int ST_STATE_LSB = 8;

  // motion states, gray along idle -> move -> show
  typedef enum logic [1:0] {
    TRH_IDLE = 2'h0,
    TRH_MOVE = 2'h1,
    TRH_SHOW = 2'h3
  } trh_state_t;

  // decoded host command
  typedef struct packed {
    logic wind;
    logic left;
    logic right;
  } trh_cmd_t;

  // character presented to the host, positive sense
  typedef struct packed {
    logic ready;
    logic [7:0] tracks;
  } trh_char_t;

endpackage

// ==== core/trh_timer.sv ====
// one-shot lockout timer: busy for a loaded number of cycles after start
`timescale 1ns/1ps
`default_nettype none
module trh_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic [W-1:0] length,
  // status
  output logic busy
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (start)
      cnt_r <= length;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign busy = (cnt_r != '0);

endmodule
`default_nettype wire

// ==== tb/trh_reader_props.sv ====
// port assertions for the tape reader drive handshake
`timescale 1ns/1ps
`default_nettype none
module trh_reader_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // host side
  input wire logic run_left_cmd_n,
  input wire logic run_right_cmd_n,
  input wire logic halt_request_n,
  input wire logic polarity_sel,
  input wire logic tape_out,
  input wire logic [7:0] track_out,
  input wire logic char_ready_out,
  input wire logic unit_ready_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pins were registered with last cycle's polarity select
  logic pol_d_r;
  always_ff @(posedge pclk)
    pol_d_r <= polarity_sel;
  wire logic rdy_act = char_ready_out ^ pol_d_r;
  wire logic [7:0] trk = track_out ^ {8{pol_d_r}};
  // outputs sit one register behind, so three held cycles are enough
  sequence halt_held;
    !halt_request_n [*3];
  endsequence
  sequence out_held;
    tape_out [*3];
  endsequence
  a_halt_unit_off: assert property (halt_held |-> unit_ready_n)
    else $error("unit ready during halt");
  a_halt_char_off: assert property (halt_held ##0 $stable(polarity_sel) |-> !rdy_act)
    else $error("char ready during halt");
  a_right_drops_ready: assert property ($fell(run_right_cmd_n) && $stable(polarity_sel) |-> ##2 !rdy_act)
    else $error("ready kept after right command");
  a_left_drops_ready: assert property ($fell(run_left_cmd_n) && $stable(polarity_sel) |-> ##2 !rdy_act)
    else $error("ready kept after left command");
  a_tape_out_unready: assert property (out_held |-> unit_ready_n)
    else $error("unit ready without tape");
  a_ready_needs_unit: assert property (rdy_act && $stable(polarity_sel) |-> !unit_ready_n)
    else $error("char ready while unit not ready");
  a_tracks_hold: assert property (rdy_act && $past(rdy_act) && $stable(polarity_sel) |-> $stable(trk))
    else $error("tracks moved under ready");
  a_unmapped_err: assert property (psel && penable |-> pslverr == (paddr > 12'h00C))
    else $error("slave error mismatch");
endmodule
`default_nettype wire

// ==== tb/trh_host.sv ====
// host controller model that commands tape motion and reads characters
`timescale 1ns/1ps
`default_nettype none
module trh_host (
  // clock
  input wire logic pclk,
  // reader outputs
  input wire logic char_ready_out,
  input wire logic polarity_sel,
  input wire logic [7:0] track_out,
  // drive lines: run right, run left, fast right, fast left
  output var logic [3:0] cmd_n
);
  wire logic act = char_ready_out ^ polarity_sel;
  initial cmd_n = 4'hF;
  task automatic wait_act(input logic v);
    while (act !== v)
      @(posedge pclk);
  endtask
  // holds one line low for n characters, or releases it once ready drops when pulse is set; cyc is command to first ready
  task automatic run(input int line, input int n, input logic pulse, output int cyc, output logic [7:0] ch);
    int k;
    time t0;
    t0 = $time;
    cmd_n[line] <= 1'b0;
    repeat (3) @(posedge pclk);
    wait_act(1'b0);
    if (pulse)
      cmd_n[line] <= 1'b1;
    for (k = 0; k < n; k++)
    begin
      if (k > 0)
        wait_act(1'b0);
      wait_act(1'b1);
      if (k == 0)
        cyc = int'(($time - t0) / 8);
    end
    ch = track_out ^ {8{polarity_sel}};
    cmd_n[line] <= 1'b1;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the tape reader drive handshake
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam int R = 200;
  localparam int W = 100;
  localparam int WL = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic wind_enable_n, halt_request_n, polarity_sel, tape_out, char_ready_out, unit_ready_n, erv;
  logic [7:0] tape_holes, track_out, ch;
  wire logic [3:0] cmd_n;
  int n_errors = 0;
  int comparisons = 0;
  int cyc;
  trh_reader #(.READ_CHAR_CYC(R), .WIND_CHAR_CYC(W), .STOP_WIN_CYC(20), .REV_LOCK_CYC(300), .WIND_LOCK_CYC(WL)) dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .run_right_cmd_n(cmd_n[0]), .run_left_cmd_n(cmd_n[1]), .fast_right_cmd_n(cmd_n[2]), .fast_left_cmd_n(cmd_n[3]),
    .wind_enable_n, .halt_request_n, .polarity_sel, .tape_holes, .tape_out, .track_out, .char_ready_out, .unit_ready_n);
  trh_host host (.pclk, .char_ready_out, .polarity_sel, .track_out, .cmd_n);
  always #4 pclk = ~pclk;
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    tally_and_finish;
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, polarity_sel, tape_out} = '0;
    {wind_enable_n, halt_request_n} = 2'b11;
    tape_holes = 8'hA5;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, trh_pkg::STATUS_OFS, 32'h0);
    `CHK("status_ready", 1'b1, rdv[trh_pkg::ST_UNIT_READY])
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped_err", 1'b1, erv)
    host.run(0, 1, 1'b1, cyc, ch);
    `CHK("step_char", 8'hA5, ch)
    `CHK("read_period", 1'b1, cyc >= R && cyc <= R + 4)
    polarity_sel <= 1'b1;
    tape_holes <= 8'h3C;
    host.run(0, 1, 1'b1, cyc, ch);
    `CHK("inv_char", 8'h3C, ch)
    `CHK("inv_tracks", ~8'h3C, track_out)
    apb(1'b0, trh_pkg::DATA_OFS, 32'h0);
    `CHK("data_reg", 32'h3C, rdv)
    polarity_sel <= 1'b0;
    host.run(0, 3, 1'b0, cyc, ch);
    apb(1'b0, trh_pkg::COUNT_OFS, 32'h0);
    `CHK("char_count", 32'h5, rdv)
    host.run(1, 1, 1'b0, cyc, ch);
    `CHK("read_rev_lock", 1'b1, cyc > R + 200)
    apb(1'b1, trh_pkg::CTRL_OFS, 32'h1);
    host.run(0, 1, 1'b0, cyc, ch);
    `CHK("no_spool_rev", 1'b1, cyc <= R + 4)
    apb(1'b1, trh_pkg::CTRL_OFS, 32'hB);
    host.wait_act(1'b0);
    host.wait_act(1'b1);
    apb(1'b1, trh_pkg::CTRL_OFS, 32'h3);
    apb(1'b0, trh_pkg::COUNT_OFS, 32'h0);
    `CHK("manual_count", 32'h8, rdv)
    wind_enable_n <= 1'b0;
    repeat (60) @(posedge pclk);
    host.run(0, 2, 1'b0, cyc, ch);
    `CHK("wind_period", 1'b1, cyc >= W && cyc <= W + 4)
    host.run(3, 1, 1'b0, cyc, ch);
    `CHK("wind_rev_lock", 1'b1, cyc > W + 250)
    host.run(3, 1, 1'b0, cyc, ch);
    `CHK("wind_stop_lock", 1'b1, cyc >= W + WL - 5 && cyc <= W + WL + 6)
    halt_request_n <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("halt_unit", 1'b1, unit_ready_n)
    `CHK("halt_char", 1'b0, char_ready_out)
    apb(1'b0, trh_pkg::STATUS_OFS, 32'h0);
    `CHK("halt_status", 2'b00, rdv[1:0])
    halt_request_n <= 1'b1;
    tape_out <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("no_tape_unit", 1'b1, unit_ready_n)
    tape_out <= 1'b0;
    apb(1'b1, trh_pkg::CTRL_OFS, 32'h0);
    @(posedge pclk);
    `CHK("load_unit", 1'b1, unit_ready_n)
    tally_and_finish;
  end
endmodule
bind trh_reader trh_reader_props props (.pclk, .presetn, .paddr, .psel, .penable, .pslverr, .run_left_cmd_n,
  .run_right_cmd_n, .halt_request_n, .polarity_sel, .tape_out, .track_out, .char_ready_out, .unit_ready_n);
`default_nettype wire
